// >>> hdl/dmcs_sequencer.sv
// character generator control: sheet select, dot readout, positioning
// Behaviour
// - low four levels pick one column driver
// - upper levels pick one of four row pairs
// - half select picks row, 4 ms each
// - column enabled by 32 ten-microsecond pulses
// - four-bit counter steps sixteen dot selects
// - seven-bit buffer holds until next pulse
// - vertical code held 20 us, then inverted
// - horizontal held 200 us, inverted 50 us
// - jet down from vertical, hold, register
// - advance steps at 8 ms, strapped period
// - advance count reached fires CR and LF
// - advance set by button, cleared by LF
// - carriage return forces first position
// - 81 characters force CR and LF
// - oscillator pulse clears CR and LF
// - line feed sources drive active-low output
// - LF, VT, FF give 4 ms extra
// - seven-bit controls and delete inhibit print
// - horizontal tab prints as a space
// - paper advance also inhibits print
// - strap lets LF decode trigger CR
// - five-bit shift codes select row set
// - start runs 250 us oscillator, 31 pulses
//
// Added by the designer: the placing of the registers and the plain strobed port.
module dmcs_sequencer #(
  parameter int STEP_CYC_P = dmcs_pkg::STEP_CYC,
  parameter int HORIZ_CYC_P = dmcs_pkg::HORIZ_HOLD_CYC,
  parameter int LF_EXTRA_P = dmcs_pkg::LF_EXTRA_CYC,
  parameter int VERT_CYC_P = dmcs_pkg::VERT_HOLD_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic char_start,
  input wire logic [6:0] char_code,
  input wire logic advance_button_n,
  input wire logic [6:0] dot_word,
  input wire dmcs_pkg::dmcs_bus_type bus,
  output logic [31:0] reg_rdata,
  output logic [15:0] col_select,
  output logic [7:0] row_drive,
  output logic row_half_select,
  output logic row_half_select_n,
  output logic mem_pulse,
  output logic [15:0] dot_select,
  output logic [3:0] vert_code,
  output logic [2:0] horiz_code,
  output logic jet_down,
  output logic [6:0] position,
  output logic position_bit_low,
  output logic carriage_return,
  output logic line_feed_out_n,
  output logic print_inhibit
);
  import dmcs_pkg::*;

  function automatic logic [15:0] onehot16(input logic [3:0] i);
    onehot16 = 16'h0001 << i;
  endfunction : onehot16

  // ==================== input synchronisers ====================
  logic [15:0] sync1;
  logic [15:0] sync2;
  logic start_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= 16'h0002;
      sync2 <= 16'h0002;
      start_q <= 1'b0;
    end else if (clk_en) begin
      sync1 <= {char_code, dot_word, advance_button_n, char_start};
      sync2 <= sync1;
      start_q <= sync2[0];
    end
  end
  logic [6:0] code_s;
  logic [6:0] dot_s;
  logic soc;
  assign code_s = sync2[15:9];
  assign dot_s = sync2[8:2];
  assign soc = sync2[0] & ~start_q;

  // ==================== register port ====================
  dmcs_ctrl_type ctrl;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
    end else if (clk_en && bus.wr && bus.addr == CTRL_ADDR) begin
      ctrl <= bus.wdata[4:0];
    end
  end

  logic running;
  logic adv;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= 32'h0;
      if (bus.rd && bus.addr == CTRL_ADDR) begin
        reg_rdata <= {27'h0, ctrl};
      end else if (bus.rd && bus.addr == STAT_ADDR) begin
        reg_rdata <= {21'h0, print_inhibit, adv, running, 1'b0,
                      position};
      end
    end
  end

  // ==================== character decode ====================
  logic figs;
  function automatic dmcs_dec_type decode(input logic [6:0] c,
                                          input logic five);
    dmcs_dec_type d;
    d = '0;
    if (five) begin
      d.lf = c[4:0] == BDT_LF;
      d.cr = c[4:0] == BDT_CR;
      d.ht = c[4:0] == BDT_HT;
      d.ltrs = c[4:0] == BDT_LTRS;
      d.figs = c[4:0] == BDT_FIGS;
      d.inhibit = d.lf | d.cr | d.ltrs | d.figs;
    end else begin
      d.lf = c == ASC_LF || c == ASC_VT || c == ASC_FF;
      d.cr = c == ASC_CR;
      d.ht = c == ASC_HT;
      d.inhibit = (c[6:5] == 2'b00 && !d.ht) || c == ASC_DEL;
    end
    return d;
  endfunction : decode

  dmcs_dec_type dec;
  assign dec = decode(code_s, ctrl.five_bit);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      figs <= 1'b0;
    end else if (clk_en && soc && ctrl.five_bit) begin
      if (dec.figs) begin
        figs <= 1'b1;
      end else if (dec.ltrs) begin
        figs <= 1'b0;
      end
    end
  end

  logic [6:0] code_q;
  logic inhibit_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= 7'h00;
      inhibit_q <= 1'b0;
    end else if (clk_en && soc) begin
      code_q <= code_s;
      inhibit_q <= dec.inhibit;
    end
  end

  // ==================== step oscillator ====================
  logic [19:0] step_cnt;
  logic [4:0] pulse_idx;
  logic tick;
  logic char_end;
  logic restart;
  assign tick = running && step_cnt == 20'(STEP_CYC_P - 1);
  assign char_end = tick && pulse_idx == LAST_PULSE - 5'h01;
  assign restart = soc | (char_end & adv);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
      step_cnt <= 20'h0;
      pulse_idx <= 5'h00;
    end else if (clk_en) begin
      if (restart) begin
        running <= 1'b1;
        step_cnt <= 20'h0;
        pulse_idx <= 5'h00;
      end else if (tick) begin
        step_cnt <= 20'h0;
        pulse_idx <= pulse_idx + 5'h01;
        running <= !char_end;
      end else if (running) begin
        step_cnt <= step_cnt + 20'h1;
      end
    end
  end

  logic mem_go;
  assign mem_go = restart | tick;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_pulse <= 1'b0;
    end else if (clk_en) begin
      mem_pulse <= mem_go;
    end
  end

  // ==================== drivers ====================
  logic [11:0] dot_cnt;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dot_cnt <= 12'h0;
    end else if (clk_en) begin
      if (mem_go) begin
        dot_cnt <= 12'(DOT_CYC);
      end else if (dot_cnt != 12'h0) begin
        dot_cnt <= dot_cnt - 12'h1;
      end
    end
  end

  logic [1:0] pair;
  assign pair = ctrl.five_bit ? {figs, code_q[4]} : code_q[5:4];
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      col_select <= 16'h0;
      row_drive <= 8'h0;
      row_half_select <= 1'b0;
      row_half_select_n <= 1'b1;
      dot_select <= 16'h0;
    end else if (clk_en) begin
      col_select <= (dot_cnt != 12'h0) ? onehot16(code_q[3:0]) : 16'h0;
      row_half_select <= pulse_idx[4];
      row_half_select_n <= ~pulse_idx[4];
      row_drive <= running ? 8'(8'h01 << {pair, pulse_idx[4]}) : 8'h0;
      dot_select <= running ? onehot16(pulse_idx[3:0]) : 16'h0;
    end
  end

  // ==================== dot code registers ====================
  logic [6:0] dot_buf;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dot_buf <= 7'h00;
    end else if (clk_en && mem_go) begin
      dot_buf <= dot_s;
    end
  end

  logic [11:0] vert_cnt;
  logic [19:0] horiz_cnt;
  logic vert_hold;
  logic horiz_hold;
  assign vert_hold = vert_cnt != 12'h0;
  assign horiz_hold = horiz_cnt != 20'h0;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vert_cnt <= 12'h0;
      horiz_cnt <= 20'h0;
    end else if (clk_en) begin
      if (mem_go) begin
        vert_cnt <= 12'(VERT_CYC_P);
        horiz_cnt <= 20'(HORIZ_CYC_P);
      end else begin
        if (vert_hold) begin
          vert_cnt <= vert_cnt - 12'h1;
        end
        if (horiz_hold) begin
          horiz_cnt <= horiz_cnt - 20'h1;
        end
      end
    end
  end

  logic jd_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vert_code <= 4'h0;
      horiz_code <= 3'h0;
      jd_reg <= 1'b0;
      jet_down <= 1'b0;
    end else if (clk_en) begin
      if (!vert_hold) begin
        vert_code <= ~dot_buf[3:0];
      end
      if (!horiz_hold) begin
        horiz_code <= ~dot_buf[6:4];
      end
      // use this character's own decode: the registered inhibit lags
      if (restart) begin
        jd_reg <= ctrl.jd_en & ~adv & ~(soc & dec.inhibit);
      end else if (!running) begin
        jd_reg <= 1'b0;
      end
      jet_down <= jd_reg & ~vert_hold & (|vert_code);
    end
  end

  // ==================== paper advance ====================
  logic adv_hit;
  logic wrap_hit;
  assign adv_hit = adv && position[ADV_BIT_BASE + 32'(ctrl.adv_sel)];
  assign wrap_hit = position[0] & position[4] & position[6];
  // set by button, cleared by LF
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      adv <= 1'b0;
    end else if (clk_en) begin
      adv <= ~sync2[1] | (adv & line_feed_out_n);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      print_inhibit <= 1'b0;
    end else if (clk_en) begin
      print_inhibit <= (inhibit_q & running) | adv;
    end
  end

  // ==================== carriage return / line feed ====================
  logic cr_flag;
  logic lf_flag;
  logic cr_set;
  logic lf_set;
  // link makes each decode fire both
  assign cr_set = (soc & (dec.cr | (ctrl.crlf_link & dec.lf)))
                  | adv_hit | wrap_hit;
  assign lf_set = (soc & (dec.lf | (ctrl.crlf_link & dec.cr)))
                  | adv_hit | wrap_hit;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cr_flag <= 1'b0;
      lf_flag <= 1'b0;
    end else if (clk_en) begin
      cr_flag <= cr_set | (cr_flag & ~tick);
      lf_flag <= lf_set | (lf_flag & ~tick);
    end
  end

  logic [19:0] lf_cnt;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lf_cnt <= 20'h0;
      line_feed_out_n <= 1'b1;
      carriage_return <= 1'b0;
    end else if (clk_en) begin
      if (lf_set) begin
        lf_cnt <= 20'(LF_EXTRA_P);
      end else if (!lf_flag && lf_cnt != 20'h0) begin
        lf_cnt <= lf_cnt - 20'h1;
      end
      line_feed_out_n <= ~(lf_flag | (lf_cnt != 20'h0));
      carriage_return <= cr_flag;
    end
  end

  // ==================== position counter ====================
  // return forces first position
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      position <= 7'h00;
      position_bit_low <= 1'b0;
    end else if (clk_en) begin
      if (cr_flag) begin
        position <= 7'h00;
      end else if (char_end && (!inhibit_q || adv)) begin
        position <= position + 7'h01;
      end
      position_bit_low <= position[1];
    end
  end

  // ==================== checks ====================
  col_onehot_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    col_select != 16'h0 |-> $onehot(col_select))
    else $error("column select not one-hot");

  row_onehot_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    row_drive != 8'h0 |-> $onehot(row_drive))
    else $error("row drive not one-hot");

  half_pair_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    row_half_select != row_half_select_n)
    else $error("half select pair not complementary");

  dot_step_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n || !clk_en)
    tick && !char_end ##1 clk_en |=> dot_select == onehot16(pulse_idx[3:0]))
    else $error("dot select did not follow counter");

  buf_hold_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !mem_go |=> $stable(dot_buf))
    else $error("buffer changed without memory pulse");

  vert_hold_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n || !clk_en)
    vert_hold |=> $stable(vert_code))
    else $error("vertical code moved during hold");

  horiz_hold_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n || !clk_en)
    mem_go |=> horiz_hold throughout (##1 1'b1 [*8]))
    else $error("horizontal hold ended early");

  jet_gate_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    jet_down |-> $past(jd_reg) && $past(!vert_hold))
    else $error("jet down outside its gate");

  wrap_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n || !clk_en)
    wrap_hit |=> cr_flag && lf_flag)
    else $error("wrap did not raise return and feed");

  lf_out_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n || !clk_en)
    lf_flag |=> !line_feed_out_n)
    else $error("line feed output not driven low");

  osc_stop_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    $fell(running) |-> pulse_idx == LAST_PULSE)
    else $error("oscillator stopped on wrong pulse");

  inhibit_a: assert property (
    @(posedge sys_clk) disable iff (!reset_n || !clk_en)
    adv |=> print_inhibit)
    else $error("advance did not inhibit print");
endmodule : dmcs_sequencer

// >>> common/dmcs_pkg.sv
// constants and carrier types for the dot matrix character sequencer
package dmcs_pkg;
  // ==================== timing ====================
  localparam int CLK_MHZ = 200;
  localparam int STEP_US = 250;
  localparam int STEP_CYC = STEP_US * CLK_MHZ;
  localparam int DOT_US = 10;
  localparam int DOT_CYC = DOT_US * CLK_MHZ;
  localparam int VERT_HOLD_US = 20;
  localparam int VERT_HOLD_CYC = VERT_HOLD_US * CLK_MHZ;
  localparam int HORIZ_HOLD_US = 200;
  localparam int HORIZ_HOLD_CYC = HORIZ_HOLD_US * CLK_MHZ;
  localparam int LF_EXTRA_MS = 4;
  localparam int LF_EXTRA_CYC = LF_EXTRA_MS * 1000 * CLK_MHZ;
  localparam logic [4:0] LAST_PULSE = 5'h1f;
  // ==================== codes ====================
  localparam logic [6:0] ASC_HT = 7'h09;
  localparam logic [6:0] ASC_LF = 7'h0a;
  localparam logic [6:0] ASC_VT = 7'h0b;
  localparam logic [6:0] ASC_FF = 7'h0c;
  localparam logic [6:0] ASC_CR = 7'h0d;
  localparam logic [6:0] ASC_DEL = 7'h7f;
  localparam logic [4:0] BDT_LF = 5'h02;
  localparam logic [4:0] BDT_CR = 5'h08;
  localparam logic [4:0] BDT_FIGS = 5'h1b;
  localparam logic [4:0] BDT_LTRS = 5'h1f;
  localparam logic [4:0] BDT_HT = 5'h00;
  // ==================== register map ====================
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;
  localparam int ADV_BIT_BASE = 1;
  typedef struct packed {
    logic jd_en;
    logic [1:0] adv_sel;
    logic crlf_link;
    logic five_bit;
  } dmcs_ctrl_type;
  localparam dmcs_ctrl_type CTRL_RESET = 5'h10;
  typedef struct packed {
    logic lf;
    logic cr;
    logic ht;
    logic inhibit;
    logic ltrs;
    logic figs;
  } dmcs_dec_type;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dmcs_bus_type;
endpackage : dmcs_pkg

// >>> bench/dmcs_memory_model.sv
// dot memory stand-in that answers the column select and row drive
module dmcs_memory_model (
  input wire logic sys_clk,
  input wire logic [15:0] col_select,
  input wire logic [7:0] row_drive,
  output logic [6:0] dot_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] word = 7'h00;
  // ==================== sheet readout ====================
  // an unselected sheet floats: invert the word every cycle, so the old word comes back every second clock
  always @(posedge sys_clk) begin
    if (col_select != 16'h0000 && row_drive != 8'h00) begin
      word <= 7'h5a;
    end else begin
      word <= ~word;
    end
  end
  assign dot_word = word;
endmodule : dmcs_memory_model

// >>> bench/tb_top.sv
// self-checking bench for the dot matrix character sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmcs_pkg::*;
  // short step keeps a character at about 640 cycles
  localparam int STEP = 20;
  localparam int LF_P = 30;
  // ==================== signals ====================
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic char_start = 1'b0;
  logic [6:0] char_code = 7'h00;
  logic advance_button_n = 1'b1;
  logic [6:0] dot_word;
  dmcs_bus_type bus_s = '0;
  logic [31:0] reg_rdata;
  logic [15:0] col_select;
  logic [7:0] row_drive;
  logic row_half_select;
  logic row_half_select_n;
  logic mem_pulse;
  logic [15:0] dot_select;
  logic [3:0] vert_code;
  logic [2:0] horiz_code;
  logic jet_down;
  logic [6:0] position;
  logic carriage_return;
  logic line_feed_out_n;
  logic print_inhibit;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int lf_cnt = 0;
  logic lf_seen = 1'b0;
  logic cr_seen = 1'b0;
  logic inh_seen = 1'b0;
  logic [7:0] row_first = 8'h00;
  logic [31:0] rdv;
  logic clk_en = 1'b1;
  logic position_bit_low;
  logic five_mode = 1'b0;
  logic adv_mode = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  // vertical hold kept below the step so jet down can rise mid-character
  dmcs_sequencer #(
    .STEP_CYC_P(STEP), .HORIZ_CYC_P(10), .LF_EXTRA_P(LF_P), .VERT_CYC_P(4)
  ) DUT (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .char_start(char_start), .char_code(char_code),
    .advance_button_n(advance_button_n), .dot_word(dot_word), .bus(bus_s),
    .reg_rdata(reg_rdata), .col_select(col_select), .row_drive(row_drive),
    .row_half_select(row_half_select), .row_half_select_n(row_half_select_n),
    .mem_pulse(mem_pulse), .dot_select(dot_select), .vert_code(vert_code),
    .horiz_code(horiz_code), .jet_down(jet_down), .position(position),
    .position_bit_low(position_bit_low),
    .carriage_return(carriage_return),
    .line_feed_out_n(line_feed_out_n), .print_inhibit(print_inhibit)
  );
  dmcs_memory_model mem (
    .sys_clk(sys_clk), .col_select(col_select), .row_drive(row_drive),
    .dot_word(dot_word)
  );
  // ==================== common tasks ====================
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask : check
  // sticky flags, so one-cycle events are not missed between checks
  always @(posedge sys_clk) begin
    cycles++;
    if (line_feed_out_n === 1'b0) begin
      lf_seen = 1'b1;
      lf_cnt++;
    end
    if (carriage_return === 1'b1) cr_seen = 1'b1;
    if (print_inhibit === 1'b1) inh_seen = 1'b1;
    if (cycles == 90000) begin
      n_errors++;
      $display("[ERR] run_time expected 90000 seen %0d", cycles);
      end_sim();
    end
  end
  task automatic clear_flags();
    lf_seen = 1'b0;
    cr_seen = 1'b0;
    inh_seen = 1'b0;
    lf_cnt = 0;
  endtask : clear_flags
  // codes that must not print in the current code mode
  function automatic logic inh_exp(input logic [6:0] c);
    if (five_mode) begin
      return c[4:0] == BDT_LF || c[4:0] == BDT_CR ||
             c[4:0] == BDT_LTRS || c[4:0] == BDT_FIGS;
    end
    return (c[6:5] == 2'b00 && c != ASC_HT) || c == ASC_DEL;
  endfunction : inh_exp
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_s <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_s.wr <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_s <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_s.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : bus_rd
  // one character: counts memory pulses and checks dot steps 2 to 30 mid-way
  task automatic send_char(input logic [6:0] code);
    int np;
    int t;
    int mark;
    int k;
    logic iexp;
    np = 0;
    t = 0;
    mark = -1;
    k = 0;
    iexp = inh_exp(code) || adv_mode;
    @(posedge sys_clk);
    char_code <= code;
    repeat (3) @(posedge sys_clk);
    char_start <= 1'b1;
    while (np < 32 && t < 40 * STEP) begin
      @(posedge sys_clk);
      if (t == 3) char_start <= 1'b0;
      #1;
      t++;
      if (mem_pulse === 1'b1) begin
        k = np;
        mark = t + 15;
        np++;
      end
      if (t == mark && k >= 2) begin
        check("half", k >= 16, row_half_select);
        check("half_n", k < 16, row_half_select_n);
        check("column", 16'h1 << code[3:0], col_select);
        check("row_onehot", 1, $onehot(row_drive));
        check("dot_sel", 16'h1 << k[3:0], dot_select);
        check("horiz", 3'h2, horiz_code);
        check("inhibit", iexp, print_inhibit);
        check("jet", !iexp, jet_down);
        if (k == 2) row_first = row_drive;
      end
    end
    if (t < 4) char_start <= 1'b0;
    check("pulses", 32, np);
    repeat (10) @(posedge sys_clk);
    #1;
  endtask : send_char
  // ==================== scenarios ====================
  task automatic test_reset();
    check("half_n_rst", 1, row_half_select_n);
    check("lf_rst", 1, line_feed_out_n);
    bus_rd(CTRL_ADDR, rdv);
    check("ctrl_rst", 32'(CTRL_RESET), rdv);
    bus_wr(8'h08, 32'h1f);
    bus_rd(8'h08, rdv);
    check("unmapped", 0, rdv);
    bus_wr(STAT_ADDR, 32'h7f);
    bus_rd(STAT_ADDR, rdv);
    check("stat_ro", 0, rdv[6:0]);
    bus_rd(CTRL_ADDR, rdv);
    check("ctrl_keep", 32'(CTRL_RESET), rdv);
    // frozen clock enable: button and bus write must leave no trace
    @(posedge sys_clk);
    clk_en <= 1'b0;
    advance_button_n <= 1'b0;
    bus_wr(CTRL_ADDR, 32'h00);
    repeat (4) @(posedge sys_clk);
    advance_button_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    clk_en <= 1'b1;
    bus_rd(STAT_ADDR, rdv);
    check("frz_adv", 0, rdv[9]);
    bus_rd(CTRL_ADDR, rdv);
    check("frz_ctrl", 32'(CTRL_RESET), rdv);
    $display("test reset done");
  endtask : test_reset
  task automatic test_print();
    logic [6:0] ctl [6] = '{ASC_LF, ASC_VT, ASC_FF, ASC_DEL, 7'h05, 7'h1f};
    int cnt;
    clear_flags();
    send_char(7'h41);
    check("pos_print", 1, position);
    check("inh_print", 0, inh_seen);
    send_char(ASC_HT);
    check("pos_tab", 2, position);
    check("inh_tab", 0, inh_seen);
    check("pos_b1", 1, position_bit_low);
    foreach (ctl[i]) begin
      clear_flags();
      send_char(ctl[i]);
      check("pos_ctl", 2, position);
      check("inh_ctl", 1, inh_seen);
      check("lf_req", i < 3, lf_seen);
      check("cr_none", 0, cr_seen);
      if (i < 3) check("lf_len", STEP + LF_P, lf_cnt);
    end
    cnt = 0;
    repeat (4100) begin
      @(posedge sys_clk);
      #1;
      if (mem_pulse === 1'b1) cnt++;
    end
    check("osc_stop", 0, cnt);
    check("vert", 4'h5, vert_code);
    // jet stays off once the character has ended
    check("jet_idle", 0, jet_down);
    clear_flags();
    send_char(ASC_CR);
    check("cr_set", 1, cr_seen);
    check("cr_pos", 0, position);
    check("cr_no_lf", 0, lf_seen);
    bus_wr(CTRL_ADDR, 32'h12);
    send_char(7'h41);
    clear_flags();
    send_char(ASC_LF);
    check("link_cr", 1, cr_seen);
    check("link_pos", 0, position);
    clear_flags();
    send_char(ASC_CR);
    check("link_lf", 1, lf_seen);
    bus_wr(CTRL_ADDR, 32'h10);
    $display("test print done");
  endtask : test_print
  task automatic test_wrap();
    repeat (80) send_char(7'h41);
    check("pos_80", 80, position);
    clear_flags();
    repeat (2) send_char(7'h41);
    check("wrap_cr", 1, cr_seen);
    check("wrap_lf", 1, lf_seen);
    check("wrap_pos", 1, position <= 2);
    $display("test wrap done");
  endtask : test_wrap
  task automatic test_advance();
    int t;
    clear_flags();
    @(posedge sys_clk);
    advance_button_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    advance_button_n <= 1'b1;
    bus_rd(STAT_ADDR, rdv);
    check("adv_set", 1, rdv[9]);
    check("adv_inh", 1, print_inhibit);
    adv_mode = 1'b1;
    send_char(7'h41);
    adv_mode = 1'b0;
    t = 0;
    while (lf_seen !== 1'b1 && t < 200 * STEP) begin
      @(posedge sys_clk);
      t++;
    end
    check("adv_lf", 1, lf_seen);
    check("adv_cr", 1, cr_seen);
    repeat (70) @(posedge sys_clk);
    bus_rd(STAT_ADDR, rdv);
    check("adv_clr", 0, rdv[9]);
    repeat (40 * STEP) @(posedge sys_clk);
    $display("test advance done");
  endtask : test_advance
  task automatic test_baudot();
    bus_wr(CTRL_ADDR, 32'h11);
    five_mode = 1'b1;
    send_char({2'b00, BDT_FIGS});
    send_char(7'h03);
    check("figs_row", 8'h10, row_first);
    send_char({2'b00, BDT_LTRS});
    send_char(7'h03);
    check("ltrs_row", 8'h01, row_first);
    clear_flags();
    send_char({2'b00, BDT_CR});
    check("bdt_cr", 1, cr_seen);
    clear_flags();
    send_char({2'b00, BDT_LF});
    check("bdt_lf", 1, lf_seen);
    send_char({2'b00, BDT_HT});
    check("bdt_ht", 1, position);
    five_mode = 1'b0;
    bus_wr(CTRL_ADDR, 32'h10);
    $display("test baudot done");
  endtask : test_baudot
  // ==================== main sequence ====================
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    test_reset();
    test_print();
    test_wrap();
    test_advance();
    test_baudot();
    end_sim();
  end
endmodule : tb_top
